// >>> src/mdlr_pkg.sv
package mdlr_pkg;

   // ************************************************************
   // register map (byte addresses, one aligned word each)
   // ************************************************************
   localparam logic [7:0] OFS_NETWORK_CONTROL = 8'h00;
   localparam logic [7:0] OFS_RX_DESC_BASE = 8'h04;
   localparam logic [7:0] OFS_STATION_LOW = 8'h08;
   localparam logic [7:0] OFS_STATION_HIGH = 8'h0C;
   localparam logic [7:0] OFS_HASH_LOW = 8'h10;
   localparam logic [7:0] OFS_HASH_HIGH = 8'h14;
   localparam logic [7:0] OFS_RX_STATUS = 8'h18;
   localparam logic [7:0] OFS_RX_DROPS = 8'h1C;

   // ************************************************************
   // network_control fields
   // ************************************************************
   localparam int LBK_LSB = 10;
   localparam int FD_BIT = 9;
   localparam int AERR_BIT = 7;
   localparam int ASHORT_BIT = 6;
   localparam int ABC_BIT = 5;
   localparam int AMC_BIT = 4;
   localparam int AUNI_BIT = 3;
   localparam int RXEN_BIT = 1;
   localparam logic [31:0] NET_CTRL_RESET = 32'h0000_0030;
   // bits 8, 2, 0 and everything above 11 are not stored
   localparam logic [31:0] NET_CTRL_WMASK = 32'h0000_0EFA;

   localparam logic [1:0] LB_NORMAL = 2'h0;
   localparam logic [1:0] LB_INTERNAL = 2'h1;
   localparam logic [1:0] LB_EXTERNAL = 2'h2;

   // ************************************************************
   // frame constants
   // ************************************************************
   localparam logic [15:0] MIN_FRAME_BYTES = 16'h0040;
   localparam logic [3:0] SFD_NIBBLE = 4'hD;
   localparam logic [2:0] DA_LAST = 3'h5;
   localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
   localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;
   localparam logic [31:0] CRC_RESIDUE = 32'hDEBB_20E3;
   localparam int HASH_MSB = 31;
   localparam int HASH_LSB = 26;

   typedef enum logic [4:0] {
      RX_OFF = 5'h01,
      RX_FETCH = 5'h02,
      RX_LISTEN = 5'h04,
      RX_PRE = 5'h08,
      RX_DATA = 5'h10
   } mdlr_rx_state_e;

   typedef struct packed {
      logic [3:0] d;
      logic dv;
      logic er;
   } mdlr_mii_s;

   typedef struct packed {
      logic [47:0] station;
      logic [63:0] hash;
      logic acc_bc;
      logic acc_mc;
      logic acc_uni;
   } mdlr_filt_cfg_s;

   // reflected crc-32, lsb of each byte first as on the wire
   function automatic logic [31:0] crc32_byte(input logic [31:0] crc, input logic [7:0] data);
      logic [31:0] c;
      c = crc;
      for (int i = 0; i < 8; i++) begin
         if (c[0] ^ data[i]) begin
            c = (c >> 1) ^ CRC_POLY;
         end else begin
            c = c >> 1;
         end
      end
      return c;
   endfunction

endpackage

// >>> src/mdlr_sync.sv
`timescale 1ns/1ps
module mdlr_sync #(
   parameter int W = 6
) (
   input wire logic core_clk, // system clock
   input wire logic resetn, // async reset, active low
   input wire logic [W-1:0] async_in, // pin levels
   output logic [W-1:0] sync_out // levels after two flops
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } mdlr_sync_st_s;

   mdlr_sync_st_s st;
   mdlr_sync_st_s next_st;

   always_comb begin
      next_st.s1 = async_in;
      next_st.s2 = st.s1;
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sync_out = st.s2;
endmodule

// >>> src/mdlr_addr_filter.sv
`timescale 1ns/1ps
module mdlr_addr_filter (
   input wire logic core_clk, // system clock
   input wire logic resetn, // async reset, active low
   input wire mdlr_pkg::mdlr_filt_cfg_s cfg, // station, hash table, accept bits
   input wire logic frame_start, // pulse before first byte
   input wire logic [7:0] byte_in, // received byte
   input wire logic byte_valid, // byte_in valid
   output logic addr_done, // destination fully seen
   output logic addr_match // destination passes the filter
);
   typedef struct packed {
      logic [2:0] cnt;
      logic [31:0] crc;
      logic [47:0] da;
      logic done;
      logic match;
   } mdlr_filt_st_s;

   mdlr_filt_st_s st;
   mdlr_filt_st_s next_st;

   function automatic logic decide(input logic [47:0] da, input logic [31:0] crc,
                                   input mdlr_pkg::mdlr_filt_cfg_s c);
      logic hit;
      hit = 1'b0;
      if (&da) begin
         hit = c.acc_bc;
      end else if (da[0]) begin
         hit = c.acc_mc && c.hash[crc[mdlr_pkg::HASH_MSB:mdlr_pkg::HASH_LSB]];
      end else begin
         hit = c.acc_uni || (da == c.station);
      end
      return hit;
   endfunction

   always_comb begin
      next_st = st;
      if (frame_start) begin
         next_st = '0;
         next_st.crc = mdlr_pkg::CRC_INIT;
      end else if (byte_valid && !st.done) begin
         next_st.crc = mdlr_pkg::crc32_byte(st.crc, byte_in);
         next_st.da[8*st.cnt +: 8] = byte_in;
         next_st.cnt = st.cnt + 3'h1;
         if (st.cnt == mdlr_pkg::DA_LAST) begin
            next_st.done = 1'b1;
            next_st.match = decide(next_st.da, next_st.crc, cfg);
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign addr_done = st.done;
   assign addr_match = st.match;
endmodule

// >>> src/mdlr_rx_ctrl.sv
// Functional notes
// - bits 11:10 select normal/internal/external loop-back
// - bit 9: full duplex concurrent, else exclusive
// - bits 8, 2, 0 read zero
// - bit 7 keeps address-matched error frames
// - bit 6 keeps address-matched frames under 64 bytes
// - bit 5 accepts broadcast destination frames
// - bit 4 accepts hash-matched multicast frames
// - bit 3 accepts all unicast, else own address
// - receive enable leaves idle, fetches first descriptor
// - disabling receive finishes current frame, then halts
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
module mdlr_rx_ctrl (
   input wire logic core_clk, // system clock, 10 MHz
   input wire logic resetn, // async reset, active low
   // apb slave
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb write
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   // mii receive pins
   input wire logic [3:0] mii_rxd, // receive nibble
   input wire logic mii_rx_dv, // receive data valid
   input wire logic mii_rx_er, // receive error
   // transmit path, same clock
   input wire logic [3:0] lb_txd, // transmit nibble for internal loop-back
   input wire logic lb_tx_en, // transmit enable for internal loop-back
   input wire logic tx_busy, // transmitter is sending
   output logic tx_permit, // transmitter may start
   output logic [1:0] loopback_select, // loop-back mode to phy and tx path
   output logic full_duplex_sel, // duplex mode to phy and tx path
   // descriptor and data path
   output logic desc_fetch_req, // fetch receive descriptor
   output logic [31:0] desc_fetch_addr, // descriptor list base
   input wire logic desc_fetch_ack, // descriptor fetched
   output logic [7:0] rx_data, // received byte
   output logic rx_data_valid, // rx_data valid, one cycle
   output logic frame_commit, // frame accepted, one cycle
   output logic frame_discard, // frame rejected, one cycle
   output logic [15:0] frame_length // bytes of the frame just ended
);
   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [31:0] net_ctrl;
      logic [31:0] rx_descriptor_list_base;
      logic [31:0] station_address_low;
      logic [15:0] station_address_high;
      logic [31:0] multicast_hash_low;
      logic [31:0] multicast_hash_high;
      logic [31:0] rdata;
      logic slverr;
      mdlr_pkg::mdlr_rx_state_e fsm;
      logic half;
      logic [3:0] low_nib;
      logic [15:0] len;
      logic [31:0] crc;
      logic err;
      logic start;
      logic [7:0] out_byte;
      logic out_valid;
      logic commit;
      logic discard;
      logic [15:0] flen;
      logic fetch;
      logic [15:0] ok_cnt;
      logic [15:0] drop_cnt;
   } mdlr_rx_st_s;

   mdlr_rx_st_s st;
   mdlr_rx_st_s next_st;
   mdlr_pkg::mdlr_mii_s pin_sync;
   mdlr_pkg::mdlr_mii_s rx_in;
   mdlr_pkg::mdlr_filt_cfg_s filt_cfg;
   logic addr_done;
   logic addr_match;
   logic access;
   logic setup;
   logic mapped;
   logic [31:0] read_mux;
   logic is_internal_lb;
   logic frame_ok;
   logic [7:0] full_byte;

   // ************************************************************
   // pins and receive source
   // ************************************************************
   mdlr_sync #(
      .W(6)
   ) u_sync (
      .core_clk(core_clk),
      .resetn(resetn),
      .async_in({mii_rxd, mii_rx_dv, mii_rx_er}),
      .sync_out(pin_sync)
   );

   assign is_internal_lb = (st.net_ctrl[mdlr_pkg::LBK_LSB +: 2] == mdlr_pkg::LB_INTERNAL);

   // internal loop-back takes the transmit nibbles, bypassing the phy
   always_comb begin
      if (is_internal_lb) begin
         rx_in.d = lb_txd;
         rx_in.dv = lb_tx_en;
         rx_in.er = 1'b0;
      end else begin
         rx_in = pin_sync;
      end
   end

   assign filt_cfg.station = {st.station_address_high, st.station_address_low};
   assign filt_cfg.hash = {st.multicast_hash_high, st.multicast_hash_low};
   assign filt_cfg.acc_bc = st.net_ctrl[mdlr_pkg::ABC_BIT];
   assign filt_cfg.acc_mc = st.net_ctrl[mdlr_pkg::AMC_BIT];
   assign filt_cfg.acc_uni = st.net_ctrl[mdlr_pkg::AUNI_BIT];

   mdlr_addr_filter u_filter (
      .core_clk(core_clk),
      .resetn(resetn),
      .cfg(filt_cfg),
      .frame_start(st.start),
      .byte_in(st.out_byte),
      .byte_valid(st.out_valid),
      .addr_done(addr_done),
      .addr_match(addr_match)
   );

   // ************************************************************
   // apb decode
   // ************************************************************
   assign setup = psel && !penable;
   assign access = psel && penable;

   always_comb begin
      mapped = 1'b1;
      read_mux = 32'h0000_0000;
      case (paddr)
         mdlr_pkg::OFS_NETWORK_CONTROL: read_mux = st.net_ctrl;
         mdlr_pkg::OFS_RX_DESC_BASE: read_mux = st.rx_descriptor_list_base;
         mdlr_pkg::OFS_STATION_LOW: read_mux = st.station_address_low;
         mdlr_pkg::OFS_STATION_HIGH: read_mux = {16'h0000, st.station_address_high};
         mdlr_pkg::OFS_HASH_LOW: read_mux = st.multicast_hash_low;
         mdlr_pkg::OFS_HASH_HIGH: read_mux = st.multicast_hash_high;
         mdlr_pkg::OFS_RX_STATUS: read_mux = {st.ok_cnt, 11'h000, st.fsm};
         mdlr_pkg::OFS_RX_DROPS: read_mux = {16'h0000, st.drop_cnt};
         default: mapped = 1'b0;
      endcase
   end

   // ************************************************************
   // end-of-frame decision
   // ************************************************************
   // with bit 7 set any frame needs only the address; otherwise frames also pass crc,
   // dribble, rx_er and, unless bit 6 is set, the short-frame check
   always_comb begin
      frame_ok = 1'b0;
      if (addr_done && addr_match) begin
         if (st.net_ctrl[mdlr_pkg::AERR_BIT]) begin
            frame_ok = 1'b1;
         end else begin
            frame_ok = !st.err && !st.half && (st.crc == mdlr_pkg::CRC_RESIDUE) &&
                       ((st.len >= mdlr_pkg::MIN_FRAME_BYTES) ||
                        st.net_ctrl[mdlr_pkg::ASHORT_BIT]);
         end
      end
   end

   assign full_byte = {rx_in.d, st.low_nib};

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      next_st = st;
      next_st.start = 1'b0;
      next_st.out_valid = 1'b0;
      next_st.commit = 1'b0;
      next_st.discard = 1'b0;

      // read data captured in setup so prdata comes from a flop
      if (setup) begin
         next_st.rdata = read_mux;
         next_st.slverr = !mapped;
      end
      if (access && pwrite) begin
         case (paddr)
            mdlr_pkg::OFS_NETWORK_CONTROL: begin
               next_st.net_ctrl = pwdata & mdlr_pkg::NET_CTRL_WMASK;
            end
            mdlr_pkg::OFS_RX_DESC_BASE: next_st.rx_descriptor_list_base = pwdata;
            mdlr_pkg::OFS_STATION_LOW: next_st.station_address_low = pwdata;
            mdlr_pkg::OFS_STATION_HIGH: next_st.station_address_high = pwdata[15:0];
            mdlr_pkg::OFS_HASH_LOW: next_st.multicast_hash_low = pwdata;
            mdlr_pkg::OFS_HASH_HIGH: next_st.multicast_hash_high = pwdata;
            default: next_st.rdata = st.rdata;
         endcase
      end

      case (st.fsm)
         mdlr_pkg::RX_OFF: begin
            if (st.net_ctrl[mdlr_pkg::RXEN_BIT]) begin
               next_st.fsm = mdlr_pkg::RX_FETCH;
               next_st.fetch = 1'b1;
            end
         end
         mdlr_pkg::RX_FETCH: begin
            if (desc_fetch_ack) begin
               next_st.fetch = 1'b0;
               next_st.fsm = mdlr_pkg::RX_LISTEN;
            end
         end
         mdlr_pkg::RX_LISTEN: begin
            if (!st.net_ctrl[mdlr_pkg::RXEN_BIT]) begin
               next_st.fsm = mdlr_pkg::RX_OFF;
            end else if (rx_in.dv && (st.net_ctrl[mdlr_pkg::FD_BIT] || !tx_busy)) begin
               next_st.fsm = mdlr_pkg::RX_PRE;
            end
         end
         mdlr_pkg::RX_PRE: begin
            if (!rx_in.dv) begin
               next_st.fsm = mdlr_pkg::RX_LISTEN;
            end else if (rx_in.d == mdlr_pkg::SFD_NIBBLE) begin
               next_st.fsm = mdlr_pkg::RX_DATA;
               next_st.start = 1'b1;
               next_st.half = 1'b0;
               next_st.len = 16'h0000;
               next_st.crc = mdlr_pkg::CRC_INIT;
               next_st.err = 1'b0;
            end
         end
         mdlr_pkg::RX_DATA: begin
            if (rx_in.dv) begin
               next_st.err = st.err || rx_in.er;
               if (!st.half) begin
                  next_st.low_nib = rx_in.d;
                  next_st.half = 1'b1;
               end else begin
                  next_st.half = 1'b0;
                  next_st.out_byte = full_byte;
                  next_st.out_valid = 1'b1;
                  next_st.len = st.len + 16'h0001;
                  next_st.crc = mdlr_pkg::crc32_byte(st.crc, full_byte);
               end
            end else begin
               // frame ends here even if receive was disabled mid-frame
               next_st.commit = frame_ok;
               next_st.discard = !frame_ok;
               next_st.flen = st.len;
               if (frame_ok) begin
                  next_st.ok_cnt = st.ok_cnt + 16'h0001;
               end else begin
                  next_st.drop_cnt = st.drop_cnt + 16'h0001;
               end
               if (st.net_ctrl[mdlr_pkg::RXEN_BIT]) begin
                  next_st.fsm = mdlr_pkg::RX_LISTEN;
               end else begin
                  next_st.fsm = mdlr_pkg::RX_OFF;
               end
            end
         end
         default: begin
            next_st.fsm = mdlr_pkg::RX_OFF;
            next_st.fetch = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
         st.net_ctrl <= mdlr_pkg::NET_CTRL_RESET;
         st.crc <= mdlr_pkg::CRC_INIT;
         st.fsm <= mdlr_pkg::RX_OFF;
      end else begin
         st <= next_st;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign prdata = st.rdata;
   assign pready = 1'b1;
   assign pslverr = access && st.slverr;
   assign loopback_select = st.net_ctrl[mdlr_pkg::LBK_LSB +: 2];
   assign full_duplex_sel = st.net_ctrl[mdlr_pkg::FD_BIT];
   // half duplex: transmitter held off while a frame is being taken in
   assign tx_permit = full_duplex_sel ||
                      !(st.fsm == mdlr_pkg::RX_PRE || st.fsm == mdlr_pkg::RX_DATA);
   assign desc_fetch_req = st.fetch;
   assign desc_fetch_addr = st.rx_descriptor_list_base;
   assign rx_data = st.out_byte;
   assign rx_data_valid = st.out_valid;
   assign frame_commit = st.commit;
   assign frame_discard = st.discard;
   assign frame_length = st.flen;
endmodule

// >>> verification/mdlr_rx_chk.sv
`timescale 1ns/1ps
module mdlr_rx_chk (
   input wire logic core_clk, // clock
   input wire logic resetn, // reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access
   input wire logic pwrite, // apb write
   input wire logic [7:0] paddr, // apb address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [31:0] prdata, // apb read data
   input wire logic pslverr, // apb error
   input wire logic tx_permit, // tx may start
   input wire logic [1:0] loopback_select, // loop-back mode
   input wire logic full_duplex_sel, // duplex mode
   input wire logic desc_fetch_req, // descriptor request
   input wire logic desc_fetch_ack, // descriptor answer
   input wire logic frame_commit, // frame kept
   input wire logic frame_discard, // frame dropped
   input wire logic rx_data_valid, // received byte strobe
   input wire logic [15:0] frame_length // length of last frame
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   logic ctl_acc;
   assign ctl_acc = psel && penable && paddr == mdlr_pkg::OFS_NETWORK_CONTROL;
   property p_lbk;
      ctl_acc && pwrite |=> loopback_select == $past(pwdata[11:10]);
   endproperty
   a_lbk: assert property (p_lbk)
      else $error("loopback_select differs from written field");
   property p_fd;
      ctl_acc && pwrite |=> full_duplex_sel == $past(pwdata[9]);
   endproperty
   a_fd: assert property (p_fd)
      else $error("full_duplex_sel differs from written bit");
   property p_fd_tx;
      rx_data_valid |-> tx_permit == full_duplex_sel;
   endproperty
   a_fd_tx: assert property (p_fd_tx)
      else $error("transmit permit disagrees with duplex during receive");
   property p_rsvd;
      ctl_acc && !pwrite |-> prdata[31:12] == 20'h00000 && !prdata[8] && !prdata[2] && !prdata[0];
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved control bits read nonzero");
   property p_one_end;
      not (frame_commit && frame_discard);
   endproperty
   a_one_end: assert property (p_one_end)
      else $error("frame both kept and dropped");
   property p_min_len;
      frame_commit |-> frame_length >= 16'h0006;
   endproperty
   a_min_len: assert property (p_min_len)
      else $error("frame without full destination kept");
   property p_fetch_cause;
      $rose(desc_fetch_req) |-> $past(ctl_acc && pwrite && pwdata[1], 2);
   endproperty
   a_fetch_cause: assert property (p_fetch_cause)
      else $error("descriptor fetch without receive enable write");
   property p_fetch_hold;
      desc_fetch_req && !desc_fetch_ack |=> desc_fetch_req;
   endproperty
   a_fetch_hold: assert property (p_fetch_hold)
      else $error("descriptor request dropped before answer");
   property p_unmapped;
      psel && penable && !pwrite && paddr > 8'h1C |-> pslverr && prdata == 32'h00000000;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not refused");
endmodule
bind mdlr_rx_ctrl mdlr_rx_chk u_chk (.core_clk(core_clk), .resetn(resetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pslverr(pslverr), .tx_permit(tx_permit), .loopback_select(loopback_select),
   .full_duplex_sel(full_duplex_sel), .desc_fetch_req(desc_fetch_req),
   .desc_fetch_ack(desc_fetch_ack), .frame_commit(frame_commit),
   .frame_discard(frame_discard), .frame_length(frame_length), .rx_data_valid(rx_data_valid));

// >>> verification/mdlr_phy_model.sv
`timescale 1ns/1ps
module mdlr_phy_model (
   input wire logic core_clk, // clock
   input wire logic go, // start one frame
   input wire logic [7:0] frm [0:79], // frame bytes incl. fcs
   input wire logic [7:0] nb, // frame length in bytes
   input wire logic with_er, // raise rx error mid-frame
   output mdlr_pkg::mdlr_mii_s mii, // pins toward the mac
   output logic busy // frame on the wire
);
   int cnt;
   logic [7:0] b;
   initial begin
      mii = '0;
      busy = 1'b0;
   end
   // idle data toggles each cycle so a stale nibble is never mistaken for data
   always @(posedge core_clk) begin
      if (!busy) begin
         mii <= '{d: ~mii.d, dv: 1'b0, er: 1'b0};
         busy <= go;
         cnt <= 0;
      end else if (cnt < 8) begin
         mii <= '{d: (cnt == 7) ? 4'hD : 4'h5, dv: 1'b1, er: 1'b0};
         cnt <= cnt + 1;
      end else if (cnt < 8 + 2 * nb) begin
         b = frm[(cnt - 8) / 2];
         mii <= '{d: cnt[0] ? b[7:4] : b[3:0], dv: 1'b1, er: with_er && cnt == 40};
         cnt <= cnt + 1;
      end else begin
         mii <= '{d: ~mii.d, dv: 1'b0, er: 1'b0};
         busy <= 1'b0;
      end
   end
endmodule

// >>> verification/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic core_clk, resetn, psel, penable, pwrite, pready, pslverr, tx_busy, tx_permit;
   logic lbm, rde, full_duplex_sel, desc_fetch_req, desc_fetch_ack, rx_data_valid;
   logic frame_commit, frame_discard, go, with_er, busy;
   logic [7:0] paddr, rx_data, nb;
   logic [31:0] pwdata, prdata, desc_fetch_addr, rdv;
   logic [1:0] loopback_select;
   logic [15:0] frame_length;
   logic [7:0] frm [0:79];
   mdlr_pkg::mdlr_mii_s mii;
   int errors = 0, tests_run = 0, cyc = 0, byte_cnt = 0, last_cnt = 0, ncom = 0, ndis = 0;
   localparam logic [7:0] CTL = mdlr_pkg::OFS_NETWORK_CONTROL;
   mdlr_rx_ctrl uut (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mii_rxd(mii.d), .mii_rx_dv(mii.dv && !lbm), .mii_rx_er(mii.er),
      .lb_txd(mii.d), .lb_tx_en(mii.dv && lbm), .tx_busy(tx_busy), .tx_permit(tx_permit),
      .loopback_select(loopback_select), .full_duplex_sel(full_duplex_sel),
      .desc_fetch_req(desc_fetch_req), .desc_fetch_addr(desc_fetch_addr),
      .desc_fetch_ack(desc_fetch_ack), .rx_data(rx_data), .rx_data_valid(rx_data_valid),
      .frame_commit(frame_commit), .frame_discard(frame_discard),
      .frame_length(frame_length));
   mdlr_phy_model phy (.core_clk(core_clk), .go(go), .frm(frm), .nb(nb), .with_er(with_er),
      .mii(mii), .busy(busy));
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   // ************************************************************
   // responders, counters, timeout
   // ************************************************************
   always @(posedge core_clk) begin
      desc_fetch_ack <= desc_fetch_req && !desc_fetch_ack;
      if (rx_data_valid === 1'b1) byte_cnt <= byte_cnt + 1;
      if (rx_data_valid === 1'b1) chk("rx_data", frm[byte_cnt], rx_data);
      if (frame_commit === 1'b1 || frame_discard === 1'b1) begin
         last_cnt <= byte_cnt;
         byte_cnt <= 0;
         ncom <= ncom + int'(frame_commit);
         ndis <= ndis + int'(frame_discard);
      end
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         conclude();
      end
   end
   task automatic conclude;
      $display("checks %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // ************************************************************
   // apb master
   // ************************************************************
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rdv, rde);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000, rdv, rde);
      chk("register read", exp, rdv);
   endtask
   task automatic enable(input logic [31:0] ctl);
      wr(CTL, ctl);
      @(negedge core_clk);
      chk("desc_fetch_req", 32'h1, desc_fetch_req);
      chk("desc_fetch_addr", 32'h0001_0000, desc_fetch_addr);
      @(posedge core_clk);
   endtask
   // ************************************************************
   // frames: kind 0 own, 1 other unicast, 2 broadcast, 3 multicast
   // ************************************************************
   task automatic send(input int kind, input int len, input bit bad, input bit er,
                       input logic [31:0] ctl, input bit mid_off, input int exp);
      logic [47:0] da;
      logic [31:0] c;
      int c0, d0, n;
      da = kind == 0 ? 48'h5544_3322_1102 : kind == 1 ? 48'h6644_3322_1102 :
           kind == 2 ? 48'hFFFF_FFFF_FFFF : 48'h0100_005E_0001;
      wr(CTL, ctl);
      c = 32'hFFFF_FFFF;
      for (int i = 0; i < len - 4; i++) begin
         frm[i] = (i < 6) ? da[8*i +: 8] : 8'(i);
         for (int k = 0; k < 8; k++) begin
            c = (c[0] ^ frm[i][k]) ? (c >> 1) ^ mdlr_pkg::CRC_POLY : c >> 1;
         end
      end
      c = ~c ^ {31'h0, bad};
      for (int i = 0; i < 4; i++) frm[len - 4 + i] = c[8*i +: 8];
      c0 = ncom;
      d0 = ndis;
      nb <= 8'(len);
      with_er <= er;
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
         if (mid_off && n == 60) wr(CTL, ctl & 32'hFFFF_FFFD);
      end while (busy !== 1'b0 && n < 400);
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (ncom + ndis == c0 + d0 && n < 12);
      chk("frame outcome", exp, (ncom - c0) + 2 * (ndis - d0));
      if (exp != 0) chk("frame_length", len, frame_length);
      if (exp != 0) chk("bytes offered", len, last_cnt);
   endtask
   initial begin
      resetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {tx_busy, lbm, go, nb, with_er, desc_fetch_ack} = '0;
      repeat (6) @(posedge core_clk);
      resetn <= 1'b1;
      @(posedge core_clk);
      rdchk(CTL, mdlr_pkg::NET_CTRL_RESET);
      wr(CTL, 32'hFFFF_FFFD);
      rdchk(CTL, 32'h0000_0EF8);
      for (int m = 0; m < 3; m++) begin
         wr(CTL, 32'(m) << 10);
         rdchk(CTL, 32'(m) << 10);
         chk("loopback_select", m, loopback_select);
      end
      apb(1'b0, 8'h20, 32'h00000000, rdv, rde);
      chk("pslverr", 32'h1, rde);
      chk("unmapped read", 32'h0, rdv);
      wr(mdlr_pkg::OFS_RX_DESC_BASE, 32'h0001_0000);
      wr(mdlr_pkg::OFS_STATION_LOW, 32'h3322_1102);
      wr(mdlr_pkg::OFS_STATION_HIGH, 32'h0000_5544);
      wr(mdlr_pkg::OFS_HASH_LOW, 32'hFFFF_FFFF);
      wr(mdlr_pkg::OFS_HASH_HIGH, 32'hFFFF_FFFF);
      enable(32'h32);
      send(0, 64, 0, 0, 32'h32, 0, 1);
      send(1, 64, 0, 0, 32'h32, 0, 2);
      send(1, 64, 0, 0, 32'h3A, 0, 1);
      send(2, 64, 0, 0, 32'h12, 0, 2);
      send(3, 64, 0, 0, 32'h32, 0, 1);
      send(3, 64, 0, 0, 32'h22, 0, 2);
      send(0, 40, 0, 0, 32'h32, 0, 2);
      send(0, 40, 0, 0, 32'h72, 0, 1);
      send(0, 64, 1, 0, 32'h32, 0, 2);
      send(0, 64, 1, 0, 32'hB2, 0, 1);
      send(1, 64, 1, 0, 32'hB2, 0, 2);
      send(0, 64, 0, 1, 32'h32, 0, 2);
      send(0, 64, 0, 1, 32'hB2, 0, 1);
      send(2, 64, 0, 0, 32'h32, 1, 1);
      send(0, 64, 0, 0, 32'h30, 0, 0);
      wr(CTL, 32'h230);
      enable(32'h232);
      tx_busy <= 1'b1;
      send(0, 64, 0, 0, 32'h232, 0, 1);
      wr(CTL, 32'h230);
      wr(CTL, 32'h030);
      enable(32'h032);
      send(0, 64, 0, 0, 32'h032, 0, 0);
      tx_busy <= 1'b0;
      lbm <= 1'b1;
      send(0, 64, 0, 0, 32'h432, 0, 1);
      conclude();
   end
endmodule
